// ---- core/tlo_fifo.sv ----
// ---------------------------------------------------------------------------
// tlo_fifo: synchronous valid/ready fifo
// ---------------------------------------------------------------------------
// assumes: one clock, async active-high reset, depth a power of two
module tlo_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    // pointers carry one extra bit so full and empty are distinct
    assign level = wr_q - rd_q;
    assign in_ready = (level != (AW+1)'(DEPTH));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage has no reset; contents are only read while valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + (AW+1)'(1);
            end
            if (pop) begin
                rd_q <= rd_q + (AW+1)'(1);
            end
        end
    end

endmodule : tlo_fifo

// ---- core/tlo_formatter.sv ----
// ---------------------------------------------------------------------------
// tlo_formatter: transmit line output stage (analog / dual rail / optical)
// ---------------------------------------------------------------------------
// assumes: clk is the internal bit-rate base; one line bit takes two clk
// cycles, the generated tx_bit_clock is high in the first and low in the
// second, so "rising edge" of the bit clock is the start of phase 0.
// data words arrive over apb, 32 line bits each, lsb first.
//
// Behaviour
// - analog line pins are used only while digital rail select is clear.
// - analog pins stay high impedance until coding set and tristate clear.
// - rail select and coding both set give dual-rail pcm on pos/neg pins.
// - dual-rail pulses are half baud when full baud is 0, full when 1.
// - dual-rail data launches at the bit clock rising edge in both modes.
// - the polarity bit sets dual-rail polarity; reset value is active low.
// - digital pins stay high impedance until rail select set, tristate off.
// - rail select set with coding clear gives single-rail optical output.
// - optical nrz data shifts on rising bit clock edges, full duty cycle.
// - optical cmi data changes on both bit clock edges as cmi requires.
// - the polarity bit sets optical polarity; reset value is active high.
// - a frame marker flags the first bit of every frame, on rising edges.
// - the frame marker is given only in optical mode.
// - during remote loop the frame marker holds no meaningful position.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
module tlo_formatter #(
    parameter int FIFO_DEPTH = 16,
    parameter int WORD_W = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_bit_clock,
    output logic tx_analog_line_a,
    output logic tx_analog_line_a_oe,
    output logic tx_analog_line_b,
    output logic tx_analog_line_b_oe,
    output logic tx_dual_rail_pos_out,
    output logic tx_dual_rail_pos_out_oe,
    output logic tx_dual_rail_neg_out,
    output logic tx_dual_rail_neg_out_oe,
    output logic tx_optical_data_out,
    output logic tx_optical_data_out_oe,
    output logic tx_frame_marker,
    output logic tx_frame_marker_oe
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int BW = $clog2(WORD_W);

    // -----------------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------------
    logic [tlo_pkg::TLO_CTRL_W-1:0] ctrl_q;
    logic [15:0] frame_len_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    wire setup_phase = psel && !penable;
    wire hit_ctrl = (paddr == tlo_pkg::TLO_OFS_CTRL);
    wire hit_status = (paddr == tlo_pkg::TLO_OFS_STATUS);
    wire hit_len = (paddr == tlo_pkg::TLO_OFS_FRAME_LEN);
    wire hit_data = (paddr == tlo_pkg::TLO_OFS_DATA);
    wire hit_any = hit_ctrl || hit_status || hit_len || hit_data;

    wire digital_rail_select = ctrl_q[tlo_pkg::TLO_BIT_DRS];
    wire tx_coding_sel_hi = ctrl_q[tlo_pkg::TLO_BIT_XC1];
    wire tx_line_tristate = ctrl_q[tlo_pkg::TLO_BIT_XLT];
    wire tx_full_baud_sel = ctrl_q[tlo_pkg::TLO_BIT_XFB];
    wire tx_output_polarity_sel = ctrl_q[tlo_pkg::TLO_BIT_XDOS];
    wire cmi_sel = ctrl_q[tlo_pkg::TLO_BIT_CMI];
    wire remote_loop = ctrl_q[tlo_pkg::TLO_BIT_RLOOP];

    // fifo write side: a data write waits in access phase while full,
    // so back-pressure reaches software through pready
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic [LW-1:0] fifo_level;
    wire access = psel && penable && !pready_q;
    wire data_wr = access && pwrite && hit_data;
    wire fifo_push = data_wr && fifo_in_ready;
    wire done = access && (!data_wr || fifo_in_ready);
    wire wr_ok = done && pwrite;

    // -----------------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------------
    tlo_pkg::tlo_mode_type mode;
    assign mode = !digital_rail_select
        ? (tx_coding_sel_hi ? tlo_pkg::TLO_MODE_ANALOG : tlo_pkg::TLO_MODE_OFF)
        : (tx_coding_sel_hi ? tlo_pkg::TLO_MODE_DUAL
                            : tlo_pkg::TLO_MODE_OPTICAL);

    // enables straight from control bits, registered at the pin
    wire en_analog = !digital_rail_select && tx_coding_sel_hi
        && !tx_line_tristate;
    wire en_digital = digital_rail_select && !tx_line_tristate;
    wire is_dual = (mode == tlo_pkg::TLO_MODE_DUAL);
    wire is_opt = (mode == tlo_pkg::TLO_MODE_OPTICAL);

    // status read value
    wire [31:0] status_val = {20'h0_0000, !fifo_out_valid, !fifo_in_ready,
        mode, 3'h0, LW'(fifo_level)};
    wire [31:0] rd_val = hit_ctrl ? 32'(ctrl_q)
        : hit_status ? status_val
        : hit_len ? {16'h0000, frame_len_q}
        : 32'h0000_0000;

    // apb handshake and register writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= tlo_pkg::TLO_CTRL_RST;
            frame_len_q <= tlo_pkg::TLO_FRAME_LEN_RST;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= done;
            pslverr_q <= done && !hit_any;
            if (done && !pwrite) begin
                prdata_q <= rd_val;
            end
            if (wr_ok && hit_ctrl) begin
                ctrl_q <= pwdata[tlo_pkg::TLO_CTRL_W-1:0];
            end
            if (wr_ok && hit_len) begin
                frame_len_q <= pwdata[15:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // -----------------------------------------------------------------------
    // transmit data path
    // -----------------------------------------------------------------------
    tlo_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[WORD_W-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    logic phase_q;
    logic [WORD_W-1:0] shift_q;
    logic [BW:0] bits_q;
    logic [15:0] bit_pos_q;
    logic ami_mark_q;
    logic cmi_one_q;
    logic hold_bit_q;
    logic hold_mark_q;
    logic hold_cmi_q;

    // a bit is taken at each rising bit clock edge; an empty fifo sends zeros
    wire bit_edge = (phase_q == tlo_pkg::TLO_PHASE_FIRST);
    wire have_bit = (bits_q != '0);
    wire cur_bit = have_bit && shift_q[0];
    wire reload = bit_edge && (bits_q <= (BW+1)'(1));
    assign fifo_out_ready = reload;
    wire frame_start = (bit_pos_q == 16'h0000);
    wire [15:0] last_pos = frame_len_q - 16'h0001;
    // the second half of a bit repeats the held bit; the shifter has
    // already moved on, so reading it would launch data mid bit
    wire line_bit = bit_edge ? cur_bit : hold_bit_q;
    wire line_mark = bit_edge ? ami_mark_q : hold_mark_q;
    wire line_cmi = bit_edge ? cmi_one_q : hold_cmi_q;

    // bit pacing, word shifter, frame position, mark alternation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_q <= tlo_pkg::TLO_PHASE_FIRST;
            shift_q <= '0;
            bits_q <= '0;
            bit_pos_q <= 16'h0000;
            ami_mark_q <= 1'b0;
            cmi_one_q <= 1'b0;
            hold_bit_q <= 1'b0;
            hold_mark_q <= 1'b0;
            hold_cmi_q <= 1'b0;
        end else begin
            phase_q <= !phase_q;
            if (bit_edge) begin
                hold_bit_q <= cur_bit;
                hold_mark_q <= ami_mark_q;
                hold_cmi_q <= cmi_one_q;
                if (reload && fifo_out_valid) begin
                    shift_q <= fifo_out_data;
                    bits_q <= (BW+1)'(WORD_W);
                end else if (have_bit) begin
                    shift_q <= shift_q >> 1;
                    bits_q <= bits_q - (BW+1)'(1);
                end
                bit_pos_q <= (bit_pos_q >= last_pos) ? 16'h0000
                    : bit_pos_q + 16'h0001;
                if (cur_bit) begin
                    ami_mark_q <= !ami_mark_q;
                    cmi_one_q <= !cmi_one_q;
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // line symbol shaping (values for the next clk, before polarity)
    // -----------------------------------------------------------------------
    // mark pulses alternate between the rails; half baud drops the pulse
    // in the second half of the bit, full baud holds it the whole bit
    wire dual_active = line_bit && (bit_edge || tx_full_baud_sel);
    wire pos_raw = dual_active && !line_mark;
    wire neg_raw = dual_active && line_mark;
    // cmi: one alternates full-bit levels, zero is low then high, so the
    // second half may change on the falling edge of the bit clock
    wire cmi_sym = line_bit ? !line_cmi : !bit_edge;
    wire nrz_sym = line_bit;
    wire opt_raw = cmi_sel ? cmi_sym : nrz_sym;
    // the marker is only meaningful outside remote loop, forced low there
    wire fm_raw = is_opt && !remote_loop && frame_start;
    // analog drive modelled as differential marks on the two line pins
    wire line_a_raw = line_bit && !line_mark;
    wire line_b_raw = line_bit && line_mark;

    // digital polarity: reset value 0 gives active-low rails, active-high
    // optical data; one bit inverts both sets together
    wire pol_dual = !tx_output_polarity_sel;
    wire pol_opt = tx_output_polarity_sel;

    // -----------------------------------------------------------------------
    // pin registers: every output straight from a flip-flop
    // -----------------------------------------------------------------------
    logic clk_q;
    logic la_q;
    logic la_oe_q;
    logic lb_q;
    logic lb_oe_q;
    logic dp_q;
    logic dp_oe_q;
    logic dn_q;
    logic dn_oe_q;
    logic od_q;
    logic od_oe_q;
    logic fm_q;
    logic fm_oe_q;

    // drive levels and enables; a pin of an unused mode is tristated
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_q <= 1'b0;
            la_q <= 1'b0;
            la_oe_q <= 1'b0;
            lb_q <= 1'b0;
            lb_oe_q <= 1'b0;
            dp_q <= 1'b0;
            dp_oe_q <= 1'b0;
            dn_q <= 1'b0;
            dn_oe_q <= 1'b0;
            od_q <= 1'b0;
            od_oe_q <= 1'b0;
            fm_q <= 1'b0;
            fm_oe_q <= 1'b0;
        end else begin
            clk_q <= bit_edge;
            la_q <= line_a_raw;
            la_oe_q <= en_analog;
            lb_q <= line_b_raw;
            lb_oe_q <= en_analog;
            dp_q <= pos_raw ^ pol_dual;
            dp_oe_q <= en_digital && is_dual;
            dn_q <= neg_raw ^ pol_dual;
            dn_oe_q <= en_digital && is_dual;
            od_q <= opt_raw ^ pol_opt;
            od_oe_q <= en_digital && is_opt;
            fm_q <= fm_raw && bit_edge ? 1'b1
                : (fm_q && !bit_edge);
            fm_oe_q <= en_digital && is_opt;
        end
    end

    assign tx_bit_clock = clk_q;
    assign tx_analog_line_a = la_q;
    assign tx_analog_line_a_oe = la_oe_q;
    assign tx_analog_line_b = lb_q;
    assign tx_analog_line_b_oe = lb_oe_q;
    assign tx_dual_rail_pos_out = dp_q;
    assign tx_dual_rail_pos_out_oe = dp_oe_q;
    assign tx_dual_rail_neg_out = dn_q;
    assign tx_dual_rail_neg_out_oe = dn_oe_q;
    assign tx_optical_data_out = od_q;
    assign tx_optical_data_out_oe = od_oe_q;
    assign tx_frame_marker = fm_q;
    assign tx_frame_marker_oe = fm_oe_q;

endmodule : tlo_formatter

// ---- dv/tb_top.sv ----
// tb_top.sv: self-checking bench for tlo_formatter
// assumes: apb master lives here; tlo_line_model reads the line pins
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // pins, clock, instances
    // ---------------------------------------------------------------
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
    logic pready, pslverr, re, tx_bit_clock;
    logic tx_analog_line_a, tx_analog_line_a_oe;
    logic tx_analog_line_b, tx_analog_line_b_oe;
    logic tx_dual_rail_pos_out, tx_dual_rail_pos_out_oe;
    logic tx_dual_rail_neg_out, tx_dual_rail_neg_out_oe;
    logic tx_optical_data_out, tx_optical_data_out_oe;
    logic tx_frame_marker, tx_frame_marker_oe;
    logic [63:0] hist_q;
    int pos_low_q, neg_low_q, mk_cnt_q, mk_gap_q;
    int n_fail = 0, n_tests = 0;
    localparam logic [31:0] WORD = 32'hA5C3_0F96; // sixteen marks
    wire [5:0] oe_all = {tx_analog_line_a_oe, tx_analog_line_b_oe,
        tx_dual_rail_pos_out_oe, tx_dual_rail_neg_out_oe,
        tx_optical_data_out_oe, tx_frame_marker_oe};
    always #4 clk = ~clk;
    tlo_formatter dut_u (.*);
    tlo_line_model far_u (.*);
    // ---------------------------------------------------------------
    // bus and check helpers
    // ---------------------------------------------------------------
    // one idle edge after release so the next setup never collides
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 3000);
        if (n >= 3000) chk("pready", 1'b1, pready);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] x,
            input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            $display("[ERR] %s expected %h seen %h", nm, x, g);
            n_fail++;
        end
    endtask : chk
    task automatic drain;
        for (int n = 0; n < 600; n++) begin
            apb(1'b0, tlo_pkg::TLO_OFS_STATUS, 32'h0000_0000);
            if (rv[11] === 1'b1) break;
        end
        repeat (80) @(posedge clk);
    endtask : drain
    function automatic bit has(input logic [63:0] h, input logic [31:0] w);
        for (int i = 0; i <= 32; i++) begin
            if (h[i +: 32] === w) return 1'b1;
        end
        return 1'b0;
    endfunction : has
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // short frames first, while the frame counter is still small
    task automatic t_marker;
        int c;
        chk("enables at reset", 6'h00, oe_all);
        apb(1'b0, tlo_pkg::TLO_OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0004, rv);
        apb(1'b1, tlo_pkg::TLO_OFS_FRAME_LEN, 32'h0000_0010);
        apb(1'b1, tlo_pkg::TLO_OFS_CTRL, 32'h0000_0001);
        repeat (120) @(posedge clk);
        chk("marker period", 32, mk_gap_q);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, tlo_pkg::TLO_OFS_CTRL, i ? 32'h0000_0003 : 32'h0000_0041);
            repeat (4) @(posedge clk);
            c = mk_cnt_q;
            repeat (100) @(posedge clk);
            chk("marker quiet", c, mk_cnt_q);
        end
    endtask : t_marker
    task automatic t_unmapped;
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk("unmapped write refused", 1, re);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped read data", 0, rv);
    endtask : t_unmapped
    task automatic t_modes;
        logic [6:0] cv [4] = '{7'h04, 7'h02, 7'h03, 7'h01};
        logic [5:0] ov [4] = '{6'h00, 6'h30, 6'h0C, 6'h03};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, tlo_pkg::TLO_OFS_CTRL, {25'h0, cv[i]});
            apb(1'b0, tlo_pkg::TLO_OFS_STATUS, 32'h0000_0000);
            chk("mode field", i, rv[9:8]);
            chk("pin enables", ov[i], oe_all);
            chk("analog idle", 2'b00,
                {tx_analog_line_a, tx_analog_line_b});
        end
    endtask : t_modes
    task automatic t_nrz;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, tlo_pkg::TLO_OFS_CTRL, i ? 32'h0000_0011 : 32'h0000_0001);
            apb(1'b1, tlo_pkg::TLO_OFS_DATA, WORD);
            drain;
            chk("nrz word", 1, has(hist_q, i ? ~WORD : WORD));
        end
    endtask : t_nrz
    // half then full baud; active-low rails count sixteen marks
    task automatic t_dual;
        int p, q;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, tlo_pkg::TLO_OFS_CTRL, i ? 32'h0000_000B : 32'h0000_0003);
            repeat (4) @(posedge clk);
            chk("idle rails", 2'b11, {tx_dual_rail_pos_out,
                tx_dual_rail_neg_out});
            p = pos_low_q;
            q = neg_low_q;
            apb(1'b1, tlo_pkg::TLO_OFS_DATA, WORD);
            drain;
            chk("pos marks", p + 8, pos_low_q);
            chk("neg marks", q + 8, neg_low_q);
        end
        apb(1'b1, tlo_pkg::TLO_OFS_CTRL, 32'h0000_0013);
        repeat (4) @(posedge clk);
        chk("inverted idle", 2'b00, {tx_dual_rail_pos_out,
            tx_dual_rail_neg_out});
    endtask : t_dual
    task automatic t_cmi;
        logic a;
        apb(1'b1, tlo_pkg::TLO_OFS_CTRL, 32'h0000_0021);
        repeat (8) @(posedge clk);
        while (tx_bit_clock !== 1'b1) @(posedge clk);
        a = tx_optical_data_out;
        @(posedge clk);
        chk("cmi zero symbol", 2'b01, {a, tx_optical_data_out});
    endtask : t_cmi
    // nineteen words outrun the line, so the last write must stall
    task automatic t_fifo;
        apb(1'b1, tlo_pkg::TLO_OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 19; i++) apb(1'b1, tlo_pkg::TLO_OFS_DATA, WORD);
        apb(1'b0, tlo_pkg::TLO_OFS_STATUS, 32'h0000_0000);
        chk("fifo full", 32'h0000_0030, {rv[10], rv[4:0]});
        drain;
        apb(1'b0, tlo_pkg::TLO_OFS_STATUS, 32'h0000_0000);
        chk("fifo drained", 32'h0000_0B00, rv);
    endtask : t_fifo
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // main sequence, then a watchdog far beyond the expected run
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_marker;
        t_unmapped;
        t_modes;
        t_nrz;
        t_dual;
        t_cmi;
        t_fifo;
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule : tb_top

// ---- dv/tlo_formatter_assertions.sv ----
// tlo_formatter_assertions.sv: port-level checker for tlo_formatter
// assumes: bound into every tlo_formatter; ctrl shadowed from apb writes
module tlo_formatter_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_bit_clock,
    input wire logic tx_analog_line_a_oe,
    input wire logic tx_dual_rail_pos_out,
    input wire logic tx_dual_rail_pos_out_oe,
    input wire logic tx_optical_data_out,
    input wire logic tx_optical_data_out_oe,
    input wire logic tx_frame_marker,
    input wire logic tx_frame_marker_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // ctrl shadow: ctrl-dependent outputs are judged only once a write has settled
    // ---------------------------------------------------------------
    logic [6:0] ctl_q;
    logic [2:0] age_q;
    wire ctl_wr = psel & penable & pready & pwrite
        & (paddr == tlo_pkg::TLO_OFS_CTRL);
    wire settled = (age_q > 3'h2);
    wire drs = ctl_q[tlo_pkg::TLO_BIT_DRS];
    wire xc1 = ctl_q[tlo_pkg::TLO_BIT_XC1];
    wire xlt = ctl_q[tlo_pkg::TLO_BIT_XLT];
    wire an_en = !drs & xc1 & !xlt;
    wire du_en = drs & xc1 & !xlt;
    wire op_en = drs & !xc1 & !xlt;
    wire act_lvl = ctl_q[tlo_pkg::TLO_BIT_XDOS];
    // age saturates so a quiet ctrl stays settled forever
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctl_q <= tlo_pkg::TLO_CTRL_RST;
            age_q <= 3'h0;
        end else if (ctl_wr) begin
            ctl_q <= pwdata[6:0];
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_analog_oe:
        assert property (settled |-> tx_analog_line_a_oe == an_en)
        else $error("analog enable wrong");
    chk_dual_oe:
        assert property (settled |-> tx_dual_rail_pos_out_oe == du_en)
        else $error("dual rail enable wrong");
    chk_optical_oe:
        assert property (settled |-> tx_optical_data_out_oe == op_en)
        else $error("optical enable wrong");
    chk_marker_oe:
        assert property (settled |-> tx_frame_marker_oe == op_en)
        else $error("marker enable wrong");
    chk_marker_quiet:
        assert property (settled && (!op_en || ctl_q[6]) |-> !tx_frame_marker)
        else $error("marker outside optical mode");
    chk_marker_width:
        assert property ($rose(tx_frame_marker)
            |-> tx_frame_marker [*2] ##1 !tx_frame_marker)
        else $error("marker not one bit wide");
    chk_marker_edge:
        assert property ($rose(tx_frame_marker) |-> $rose(tx_bit_clock))
        else $error("marker off the bit start");
    chk_half_baud:
        assert property (settled && du_en && !ctl_q[3]
            && tx_dual_rail_pos_out == act_lvl |-> tx_bit_clock)
        else $error("half baud pulse too long");
    chk_nrz_edge:
        assert property (settled && op_en && !ctl_q[5]
            && $changed(tx_optical_data_out) |-> $rose(tx_bit_clock))
        else $error("nrz data moved mid bit");
    chk_bitclk_run:
        assert property ($rose(tx_bit_clock)
            |-> ##1 !tx_bit_clock ##1 tx_bit_clock)
        else $error("bit clock not two cycles");
    cov_marker: cover property ($rose(tx_frame_marker));
    cov_refused: cover property (pslverr);
    cov_dual_mark: cover property (settled && du_en
        && tx_dual_rail_pos_out == act_lvl);
endmodule : tlo_formatter_chk

bind tlo_formatter tlo_formatter_chk chk_u (.*);

// ---- dv/tlo_line_model.sv ----
// tlo_line_model.sv: far-end receiver on the transmit pins
// assumes: a line bit is read in the clk cycle where tx_bit_clock rose
module tlo_line_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic tx_bit_clock,
    input wire logic tx_optical_data_out,
    input wire logic tx_optical_data_out_oe,
    input wire logic tx_dual_rail_pos_out,
    input wire logic tx_dual_rail_neg_out,
    input wire logic tx_frame_marker,
    output logic [63:0] hist_q,
    output int pos_low_q,
    output int neg_low_q,
    output int mk_cnt_q,
    output int mk_gap_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bclk_q, mk_q;
    int gap_q;
    // a released line must not look like held data, so it flips
    wire opt_lvl = tx_optical_data_out_oe ? tx_optical_data_out : ~hist_q[63];
    // bit capture, active-low mark counts, marker spacing in clk cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {bclk_q, mk_q, hist_q} <= '0;
            {pos_low_q, neg_low_q, mk_cnt_q, mk_gap_q, gap_q} <= '0;
        end else begin
            bclk_q <= tx_bit_clock;
            mk_q <= tx_frame_marker;
            gap_q <= gap_q + 1;
            if (tx_bit_clock && !bclk_q) begin
                hist_q <= {opt_lvl, hist_q[63:1]};
                pos_low_q <= pos_low_q + int'(!tx_dual_rail_pos_out);
                neg_low_q <= neg_low_q + int'(!tx_dual_rail_neg_out);
            end
            if (tx_frame_marker && !mk_q) begin
                mk_cnt_q <= mk_cnt_q + 1;
                mk_gap_q <= gap_q;
                gap_q <= 1;
            end
        end
    end
endmodule : tlo_line_model

// ---- shared/tlo_pkg.sv ----
// ---------------------------------------------------------------------------
// tlo_pkg: constants shared by the transmit line output formatter
// ---------------------------------------------------------------------------
// assumes: single clock domain (clk), APB slave with 32-bit data
package tlo_pkg;

    // register byte offsets
    localparam logic [7:0] TLO_OFS_CTRL = 8'h00;
    localparam logic [7:0] TLO_OFS_STATUS = 8'h04;
    localparam logic [7:0] TLO_OFS_FRAME_LEN = 8'h08;
    localparam logic [7:0] TLO_OFS_DATA = 8'h0C;

    // control field positions
    localparam int TLO_BIT_DRS = 0;
    localparam int TLO_BIT_XC1 = 1;
    localparam int TLO_BIT_XLT = 2;
    localparam int TLO_BIT_XFB = 3;
    localparam int TLO_BIT_XDOS = 4;
    localparam int TLO_BIT_CMI = 5;
    localparam int TLO_BIT_RLOOP = 6;
    localparam int TLO_CTRL_W = 7;

    // control reset: tristate set, everything else clear
    localparam logic [6:0] TLO_CTRL_RST = 7'h04;

    // status field positions
    localparam int TLO_ST_LEVEL = 0;
    localparam int TLO_ST_LEVEL_W = 5;
    localparam int TLO_ST_MODE = 8;
    localparam int TLO_ST_FULL = 10;
    localparam int TLO_ST_EMPTY = 11;

    // bit periods per frame, default 256 (E1)
    localparam logic [15:0] TLO_FRAME_LEN_RST = 16'h0100;

    // baud phases: each bit spans two system clocks (edge a / edge b)
    localparam logic [0:0] TLO_PHASE_FIRST = 1'h0;

    // output modes
    typedef enum logic [1:0] {
        TLO_MODE_OFF = 2'b00,
        TLO_MODE_ANALOG = 2'b01,
        TLO_MODE_DUAL = 2'b10,
        TLO_MODE_OPTICAL = 2'b11
    } tlo_mode_type;

endpackage : tlo_pkg
